/* File: design/sao_exec.sv */
// executor for software interrupt, or-immediate and or-register instructions
`timescale 1ns/1ps
// What this block does
// - software interrupt pushes program_counter plus one onto the call stack first.
// - software interrupt then loads program_counter with vector 0x001.
// - or-immediate ors accumulator with 8-bit literal and updates zero flag.
// - or-immediate writes only the accumulator, never data memory.
// - or-register ors accumulator with register 0..63 and updates zero flag.
// - destination bit 0 writes accumulator, register left unchanged.
// - destination bit 1 writes register back, accumulator left unchanged.
module sao_exec (
  input  wire logic               mclk,
  input  wire logic               arst_n,
  input  wire sao_pkg::sao_instr_t instr,
  input  wire logic               instr_valid,
  output logic                    instr_ready,
  output sao_pkg::sao_state_t     state_out,
  output sao_pkg::sao_push_t      stack_push,
  output logic                    done
);
  import sao_pkg::*;

  typedef enum logic [1:0] {
    SAO_IDLE,
    SAO_SWI_PUSH,
    SAO_SWI_VEC
  } sao_fsm_t;

  sao_fsm_t       state_ff;
  sao_fsm_t       nxt_state;
  logic [9:0]     pc_ff;
  logic [9:0]     nxt_pc;
  logic [7:0]     acc_ff;
  logic [7:0]     nxt_acc;
  logic           zero_ff;
  logic           nxt_zero;
  logic           push_ff;
  logic           nxt_push;
  logic [9:0]     push_addr_ff;
  logic [9:0]     nxt_push_addr;
  logic           done_ff;
  logic           nxt_done;
  logic           ready_ff;
  logic           nxt_ready;
  logic [7:0]     dmem_ff [REG_COUNT];
  logic           dmem_we;
  logic [5:0]     dmem_idx;
  logic [7:0]     dmem_wdata;
  logic           take;
  logic           take_swi;
  logic           take_imm;
  logic           take_reg;
  logic           take_none;
  logic [9:0]     pc_plus_one;
  logic [7:0]     operand;
  logic [7:0]     or_result;
  logic           or_zero;

  // issue decode; instr is only looked at while the port is open, so an
  // instruction held during a software interrupt is dropped without a flag
  always_comb begin
    take      = instr_valid && ready_ff && (state_ff == SAO_IDLE);
    take_swi  = 1'b0;
    take_imm  = 1'b0;
    take_reg  = 1'b0;
    take_none = 1'b0;
    if (take) begin
      unique case (instr.op)
        SAO_OP_SWI: begin
          take_swi = 1'b1;
        end
        SAO_OP_OR_IMM: begin
          take_imm = 1'b1;
        end
        SAO_OP_OR_REG: begin
          take_reg = 1'b1;
        end
        SAO_OP_NONE: begin
          take_none = 1'b1;
        end
      endcase
    end
  end

  // return address and sequential advance share one incrementer
  always_comb begin
    pc_plus_one = pc_ff + 10'h001;
  end

  // operand select: literal or data-memory register, then the shared or;
  // the register read is combinational so or-register needs no extra cycle
  always_comb begin
    if (instr.op == SAO_OP_OR_IMM) begin
      operand = instr.imm;
    end else begin
      operand = dmem_ff[instr.reg_idx];
    end
    or_result = acc_ff | operand;
    or_zero   = (or_result == 8'h00);
  end

  // sequencer; the software interrupt closes the issue port for the two cycles after its issue
  // so the stale fetch behind it can never reach the datapath
  always_comb begin
    nxt_state     = state_ff;
    nxt_ready     = ready_ff;
    nxt_push      = 1'b0;
    nxt_push_addr = push_addr_ff;
    nxt_done      = 1'b0;
    unique case (state_ff)
      SAO_IDLE: begin
        if (take_swi) begin
          nxt_push      = 1'b1;
          nxt_push_addr = pc_plus_one;
          nxt_ready     = 1'b0;
          nxt_state     = SAO_SWI_PUSH;
        end else if (take_imm || take_reg) begin
          nxt_done = 1'b1;
        end
      end
      SAO_SWI_PUSH: begin
        // return address went out on the previous edge; vector now
        nxt_state = SAO_SWI_VEC;
      end
      SAO_SWI_VEC: begin
        // third cycle flushes the stale fetch, then reopens issue
        nxt_done  = 1'b1;
        nxt_ready = 1'b1;
        nxt_state = SAO_IDLE;
      end
      default: begin
        // unused code: recover to idle with the port open
        nxt_state = SAO_IDLE;
        nxt_ready = 1'b1;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff     <= SAO_IDLE;
      ready_ff     <= 1'b1;
      push_ff      <= 1'b0;
      push_addr_ff <= PC_RESET;
      done_ff      <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      ready_ff     <= nxt_ready;
      push_ff      <= nxt_push;
      push_addr_ff <= nxt_push_addr;
      done_ff      <= nxt_done;
    end
  end

  // program counter, accumulator and zero flag; the software interrupt
  // leaves accumulator and zero alone, only the two or forms touch them
  always_comb begin
    nxt_pc   = pc_ff;
    nxt_acc  = acc_ff;
    nxt_zero = zero_ff;
    if (take_imm) begin
      nxt_acc  = or_result;
      nxt_zero = or_zero;
    end
    if (take_reg) begin
      nxt_zero = or_zero;
      if (!instr.dest_sel) begin
        nxt_acc = or_result;
      end
    end
    if (take_imm || take_reg || take_none) begin
      nxt_pc = pc_plus_one;
    end
    if (state_ff == SAO_SWI_PUSH) begin
      // vector only after the return address is on the stack
      nxt_pc = SWI_VECTOR;
    end
  end

  // datapath registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pc_ff   <= PC_RESET;
      acc_ff  <= ACC_RESET;
      zero_ff <= ZERO_RESET;
    end else begin
      pc_ff   <= nxt_pc;
      acc_ff  <= nxt_acc;
      zero_ff <= nxt_zero;
    end
  end

  // data memory write port; the write lands on the same edge as done, so a
  // back-to-back or-register reads the new value
  always_comb begin
    dmem_we    = take_reg && instr.dest_sel;
    dmem_idx   = instr.reg_idx;
    dmem_wdata = or_result;
  end

  // data memory; clearing every word on reset costs fan-out but keeps
  // the first or-register result defined
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        dmem_ff[i] <= DMEM_RESET;
      end
    end else if (dmem_we) begin
      dmem_ff[dmem_idx] <= dmem_wdata;
    end
  end

  // outputs come straight from registers
  assign state_out.program_counter = pc_ff;
  assign state_out.accumulator     = acc_ff;
  assign state_out.zero_flag       = zero_ff;
  assign stack_push.push           = push_ff;
  assign stack_push.addr           = push_addr_ff;
  assign done                      = done_ff;
  assign instr_ready               = ready_ff;
endmodule

/* File: include/sao_pkg.sv */
// package for the software interrupt and or instruction executor
package sao_pkg;
  localparam int PC_W        = 10;
  localparam int DATA_W      = 8;
  localparam int REG_IDX_W   = 6;
  localparam int REG_COUNT   = 64;
  localparam logic [9:0] SWI_VECTOR   = 10'h001;
  localparam logic [9:0] PC_RESET     = 10'h000;
  localparam logic [7:0] ACC_RESET    = 8'h00;
  localparam logic [7:0] DMEM_RESET   = 8'h00;
  localparam logic       ZERO_RESET   = 1'b0;
  localparam logic [1:0] SWI_CYCLES   = 2'h3;
  localparam logic [1:0] OR_CYCLES    = 2'h1;

  typedef enum logic [1:0] {
    SAO_OP_NONE,
    SAO_OP_SWI,
    SAO_OP_OR_IMM,
    SAO_OP_OR_REG
  } sao_op_t;

  // one instruction as issued by the fetch stage
  typedef struct packed {
    sao_op_t         op;
    logic [7:0]      imm;
    logic [5:0]      reg_idx;
    logic            dest_sel;
  } sao_instr_t;

  // core state made visible to the rest of the core
  typedef struct packed {
    logic [9:0]      program_counter;
    logic [7:0]      accumulator;
    logic            zero_flag;
  } sao_state_t;

  // one push onto the hardware call stack
  typedef struct packed {
    logic            push;
    logic [9:0]      addr;
  } sao_push_t;
endpackage

/* File: sim/sao_exec_asserts.sv */
// checker for the instruction executor
`timescale 1ns/1ps
module sao_exec_asserts (
  input wire logic                mclk,
  input wire logic                arst_n,
  input wire sao_pkg::sao_instr_t instr,
  input wire logic                instr_valid,
  input wire logic                instr_ready,
  input wire sao_pkg::sao_state_t state_out,
  input wire sao_pkg::sao_push_t  stack_push,
  input wire logic                done
);
  import sao_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // taken requests by kind
  wire tk = instr_valid && instr_ready;
  wire sw = tk && instr.op == SAO_OP_SWI;
  wire im = tk && instr.op == SAO_OP_OR_IMM;
  wire rg = tk && instr.op == SAO_OP_OR_REG;
  wire [9:0] pc = state_out.program_counter;
  wire [7:0] acc = state_out.accumulator;
  a_swi_push: assert property (
    sw |=> stack_push.push && stack_push.addr == $past(pc) + 10'h001) else $error("bad push");
  a_swi_vector: assert property (
    sw |=> ##1 pc == SWI_VECTOR) else $error("bad vector");
  a_swi_len: assert property (
    sw |=> !done ##1 !done ##1 done) else $error("bad swi length");
  a_swi_busy: assert property (
    sw |=> !instr_ready [*2] ##1 instr_ready) else $error("bad ready");
  a_or_done: assert property (
    im || rg |=> done) else $error("or not done");
  a_imm_acc: assert property (
    im |=> acc == ($past(acc) | $past(instr.imm)) && state_out.zero_flag == (acc == 8'h00)) else $error("bad imm");
  a_reg_acc: assert property (
    rg && !instr.dest_sel |=> (acc & $past(acc)) == $past(acc) && state_out.zero_flag == (acc == 8'h00))
    else $error("bad reg");
  a_reg_keep: assert property (
    rg && instr.dest_sel |=> acc == $past(acc)) else $error("acc changed");
endmodule
bind sao_exec sao_exec_asserts sao_exec_asserts_i (.*);

/* File: sim/sao_exec_tb_top.sv */
// bench for the instruction executor
`timescale 1ns/1ps
module sao_exec_tb_top;
  import sao_pkg::*;
  logic mclk = 0, arst_n = 0, instr_valid = 0, instr_ready, done;
  logic [7:0] dmem [64], res;
  sao_instr_t instr = '0, i;
  sao_state_t state_out, m, q_st[$];
  sao_push_t stack_push;
  logic [9:0] q_pa[$];
  int n_mismatch = 0, compares = 0, seed = 32'hc06d;
  sao_exec sao_exec_i (.mclk(mclk), .arst_n(arst_n), .instr(instr), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .state_out(state_out), .stack_push(stack_push), .done(done));
  always #50 mclk = ~mclk;
  task chk(input string s, input logic [18:0] e, g);
    compares++;
    if (e !== g) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  // results meet the oldest note of their kind
  always @(negedge mclk) begin
    if (done === 1'b1) chk("state", q_st.size() ? q_st.pop_front() : 'x, state_out);
    if (stack_push.push === 1'b1) chk("push", q_pa.size() ? q_pa.pop_front() : 'x, stack_push.addr);
  end
  task stop_test;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // four rounds, each after a reset, since or alone can never clear the accumulator
  initial begin
    for (int r = 0; r < 4; r++) begin
      arst_n <= 1'b0;
      m = '0;
      foreach (dmem[k]) dmem[k] = 8'h00;
      repeat (16) @(posedge mclk);
      arst_n <= 1'b1;
      @(posedge mclk);
      chk("reset", '0, state_out);
      repeat (40) begin
        i = 17'($random(seed));
        i.op = sao_op_t'(2'($unsigned($random(seed)) % 4)); // every code, the empty slot too
        i.imm &= 8'($random(seed) & $random(seed)); // sparse so zero results occur
        i.reg_idx[5:2] = 4'hF; // few registers so written values are read again
        res = m.accumulator | (i.op == SAO_OP_OR_IMM ? i.imm : dmem[i.reg_idx]);
        if (i.op == SAO_OP_SWI) q_pa.push_back(m.program_counter + 10'h001);
        m.program_counter = i.op == SAO_OP_SWI ? SWI_VECTOR : m.program_counter + 10'h001;
        if (i.op inside {SAO_OP_OR_IMM, SAO_OP_OR_REG}) m.zero_flag = res == 8'h00;
        if (i.op == SAO_OP_OR_REG && i.dest_sel) dmem[i.reg_idx] = res;
        else if (i.op inside {SAO_OP_OR_IMM, SAO_OP_OR_REG}) m.accumulator = res;
        if (i.op != SAO_OP_NONE) q_st.push_back(m); // empty slot only moves the counter, no done
        instr <= i;
        instr_valid <= 1'b1;
        @(posedge mclk);
        if (i.op == SAO_OP_SWI) begin
          instr.op <= SAO_OP_OR_IMM; // held while busy, must be ignored
          repeat (2) @(posedge mclk);
        end
      end
      instr_valid <= 1'b0;
      repeat (4) @(posedge mclk);
      $display("round %0d done", r);
    end
    chk("left", 19'h0, 19'(q_st.size() + q_pa.size()));
    stop_test;
  end
endmodule
